// File: core/dcsp_satellite.sv
// Satellite protocol engine: framing, enumeration, buffer gating, replies
`timescale 1ns/10ps
`default_nettype none
`include "dcsp_defines.svh"
module dcsp_satellite
  import dcsp_pkg::*;
#(
  parameter int         BIT_CYC    = `DCSP_BIT_CYC,
  parameter int         UP_CYC     = `DCSP_UP_CYC,
  parameter int         FIFO_DEPTH = `DCSP_FIFO_DEPTH,
  parameter logic [6:0] CLASS_FAST = 7'h41, // Arbitrary class code
  parameter logic [6:0] CLASS_SLOW = 7'h42  // Arbitrary class code
) (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       rxFromHost,
  output logic            txToHost,
  output logic            rtsToHost,
  output logic            txToBelow,
  input  wire logic       rxFromBelow,
  input  wire logic       rtsFromBelow,
  input  wire logic       modelSlow,
  input  wire logic       attnReq,
  output logic            numbered,
  output logic            remoteMode,
  output logic [6:0]      dispLetter,
  output logic [6:0]      dispTens,
  output logic [6:0]      dispOnes,
  output logic            cmdStrobe,
  output logic [6:0]      cmdChar,
  output logic            enqPoll
);
  logic        rstMetaN_q;
  logic        rstN_q;
  dcsp_state_t q, d;
  logic [6:0]  c;
  logic        e;
  logic        take;
  logic        enqHit;
  logic        crHit;
  logic        assignWait;
  logic        isBc;
  logic        isOurs;
  logic        bad;
  logic        assignOk;

  dcsp_stream_if #(.W(`DCSP_CHAR_W)) rxRaw ();
  dcsp_stream_if #(.W(`DCSP_CHAR_W)) rxq ();

  function automatic logic [9:0] txFrame(input logic [6:0] ch);
    txFrame = {1'b1, ~^ch, ch, 1'b0};
  endfunction

  function automatic logic isDigit(input logic [6:0] ch);
    isDigit = (ch >= `DCSP_DIGIT0) && (ch <= `DCSP_DIGIT9);
  endfunction

  // 01..89 only; 00 and 90..98 reserved, 99 handled as broadcast
  function automatic logic addrOk(input logic [6:0] h, input logic [6:0] l);
    addrOk = isDigit(l) && (h >= `DCSP_DIGIT0) && (h <= `DCSP_DIGIT8)
             && !((h == `DCSP_DIGIT0) && (l == `DCSP_DIGIT0));
  endfunction

  function automatic logic isReq(input logic [6:0] ch);
    isReq = (ch == `DCSP_REQ_AUX) || (ch == `DCSP_REQ_STAT);
  endfunction

  function automatic logic [2:0] msgLen(input dcsp_msg_t m);
    msgLen = (m == M_CLASS) ? 3'h5 : 3'h1;
  endfunction

  function automatic logic [6:0] msgChar(input dcsp_msg_t m, input logic [2:0] i,
                                         input logic slow);
    case (m)
      M_ACK: msgChar = `DCSP_ACK;
      M_NAK: msgChar = `DCSP_NAK;
      default: begin
        case (i)
          3'h0: msgChar = `DCSP_STX;
          3'h1: msgChar = `DCSP_PUMP;
          3'h2: msgChar = `DCSP_QMARK;
          3'h3: msgChar = slow ? CLASS_SLOW : CLASS_FAST;
          default: msgChar = `DCSP_CR;
        endcase
      end
    endcase
  endfunction

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMetaN_q <= 1'b0;
      rstN_q     <= 1'b0;
    end else begin
      rstMetaN_q <= 1'b1;
      rstN_q     <= rstMetaN_q;
    end
  end

  dcsp_uart_rx #(.BIT_CYC(BIT_CYC)) uRx (
    .core_clk (core_clk),
    .rstN     (rstN_q),
    .rxLine   (q.hs2),
    .out      (rxRaw)
  );

  // Parser stalls while replying, so the FIFO absorbs chained input
  dcsp_fifo #(.W(`DCSP_CHAR_W), .DEPTH(FIFO_DEPTH)) uFifo (
    .core_clk (core_clk),
    .rstN     (rstN_q),
    .wr       (rxRaw),
    .rd       (rxq)
  );

  assign rxq.ready  = (q.ps != PS_REPLY);
  assign take       = rxq.valid && rxq.ready;
  assign c          = rxq.data[6:0];
  assign e          = rxq.data[7];
  assign enqHit     = take && (q.ps == PS_IDLE) && !e && (c == `DCSP_ENQ) && q.rts;
  assign crHit      = take && (q.ps == PS_FRAME) && (c == `DCSP_CR);
  assign assignWait = !q.numbered && (q.ls == LS_BLOCKED);
  assign isBc       = (q.letter == `DCSP_PUMP) && (q.aHi == `DCSP_DIGIT9)
                      && (q.aLo == `DCSP_DIGIT9);
  assign isOurs     = q.numbered && (q.letter == `DCSP_PUMP)
                      && (q.aHi == q.nHi) && (q.aLo == q.nLo);
  assign bad        = q.err | e | q.ovf;
  assign assignOk   = crHit && assignWait && !bad && (q.ix == `DCSP_IX_CMD)
                      && (q.letter == `DCSP_PUMP) && addrOk(q.aHi, q.aLo);

  always_comb begin
    logic      rg;
    dcsp_msg_t rk;
    rg = 1'b0;
    rk = M_ACK;
    d  = q;
    d.hs1    = rxFromHost;
    d.hs2    = q.hs1;
    d.bs1    = rxFromBelow;
    d.bs2    = q.bs1;
    d.rs1    = rtsFromBelow;
    d.rs2    = q.rs1;
    d.ms1    = modelSlow;
    d.ms2    = q.ms1;
    d.cmdStb = 1'b0;
    d.enqPls = 1'b0;
    // Bit serializer, LSB first after the start bit
    if (q.txBusy) begin
      if (q.txCnt == 16'h0000) begin
        d.txCnt = 16'(BIT_CYC - 1);
        d.txSh  = {1'b1, q.txSh[9:1]};
        if (q.txBit == `DCSP_FRAME_BITS - 4'h1) d.txBusy = 1'b0; // RULE1
        else d.txBit = q.txBit + 4'h1;
      end else begin
        d.txCnt = q.txCnt - 16'h0001;
      end
    end
    // Reply sequencer: only runs after the master asked for something
    if ((q.ps == PS_REPLY) && !q.txBusy) begin // RULE3
      if (q.msgIx == msgLen(q.msg)) begin
        d.ps = PS_IDLE;
        if (q.numbered && !q.rts && (q.ls == LS_BLOCKED)) begin
          d.ls    = LS_GUARD;
          d.guard = 24'h000000;
        end
      end else begin
        d.txSh   = txFrame(msgChar(q.msg, q.msgIx, q.ms2)); // RULE1 RULE2 RULE7
        d.txBusy = 1'b1;
        d.txCnt  = 16'(BIT_CYC - 1);
        d.txBit  = 4'h0;
        d.msgIx  = q.msgIx + 3'h1;
      end
    end
    // Upstream path reopens a bounded time after the last reply byte or after the master's release acknowledge
    if (q.ls == LS_GUARD) begin
      if (q.guard >= 24'(UP_CYC - 1)) begin
        d.upEn = 1'b1; // RULE10
        d.ls   = LS_OPEN;
      end else begin
        d.guard = q.guard + 24'h000001;
      end
    end
    if (take) begin
      case (q.ps)
        PS_IDLE: begin
          if (!e && (c == `DCSP_STX)) begin
            d.ps  = PS_FRAME; // RULE19
            d.ix  = `DCSP_IX_LETTER;
            d.ovf = 1'b0;
            d.err = 1'b0;
            d.cmd = 7'h00;
          end else if (enqHit) begin
            d.downEn = 1'b0; // RULE6 RULE24
            d.upEn   = 1'b0;
            d.ls     = LS_BLOCKED;
            if (q.numbered) d.enqPls = 1'b1;
            else begin
              rg = 1'b1; // RULE7
              rk = M_CLASS;
            end
          end else if (!e && (c == `DCSP_ACK) && q.rts && q.numbered
                       && (q.ls == LS_BLOCKED)) begin
            d.rts    = 1'b0;
            d.downEn = 1'b1;
            d.ls     = LS_GUARD;
            d.guard  = 24'h000000;
          end else if (e && assignWait) begin
            rg = 1'b1; // RULE13
            rk = M_NAK;
          end
        end
        PS_FRAME: begin
          d.err = q.err | e; // RULE25
          if (c == `DCSP_CR) begin
            d.ps = PS_IDLE; // RULE21
            if (assignWait) begin
              rg = 1'b1;
              if (assignOk) begin
                d.numbered = 1'b1; // RULE11 RULE14
                d.nHi      = q.aHi;
                d.nLo      = q.aLo;
                d.rts      = 1'b0; // RULE9
                d.downEn   = 1'b1;
                d.remote   = 1'b1;
                rk         = M_ACK;
              end else begin
                rk = M_NAK; // RULE13 RULE26
              end
            end else if (q.numbered && (isOurs || isBc)) begin // RULE20
              if (bad) begin
                rg = !isBc; // RULE13 RULE26
                rk = M_NAK;
              end else begin
                rg = !isBc; // RULE23
                rk = M_ACK;
                if ((q.cmd == `DCSP_RENUM) && (q.ix == `DCSP_IX_RENUM_CR) && !isBc
                    && addrOk(q.wHi, q.wLo)) begin
                  d.nHi = q.wHi; // RULE15
                  d.nLo = q.wLo;
                end else if (q.cmd == `DCSP_LOCAL) begin
                  d.remote = 1'b0; // RULE18
                end else if ((q.ix > `DCSP_IX_CMD) && (q.remote || isReq(q.cmd))) begin
                  d.cmdStb = 1'b1; // RULE18
                  d.cmdChr = q.cmd;
                end
              end
            end
          end else if (q.ix == `DCSP_MAX_FRAME - 6'h01) begin
            d.ovf = 1'b1; // RULE22 RULE26
          end else begin
            d.ix = q.ix + 6'h01;
            case (q.ix)
              `DCSP_IX_LETTER: d.letter = c;
              `DCSP_IX_ADR_HI: d.aHi = c;
              `DCSP_IX_ADR_LO: d.aLo = c;
              `DCSP_IX_CMD:    d.cmd = c;
              `DCSP_IX_NEW_HI: d.wHi = c;
              `DCSP_IX_NEW_LO: d.wLo = c;
              default: ;
            endcase
          end
        end
        default: d.ps = PS_IDLE;
      endcase
    end
    // A new request wins over a release in the same cycle
    if (attnReq && q.numbered) d.rts = 1'b1; // RULE3
    if (rg) begin
      d.ps    = PS_REPLY;
      d.msg   = rk;
      d.msgIx = 3'h0;
    end
  end

  // Power-up state: unnumbered, both paths open, request raised
  always_ff @(posedge core_clk or negedge rstN_q) begin
    if (!rstN_q) begin
      q        <= '0; // RULE17
      q.hs1    <= 1'b1;
      q.hs2    <= 1'b1;
      q.bs1    <= 1'b1;
      q.bs2    <= 1'b1;
      q.ps     <= PS_IDLE;
      q.ls     <= LS_OPEN;
      q.rts    <= 1'b1; // RULE4
      q.downEn <= 1'b1;
      q.upEn   <= 1'b1;
      q.txSh   <= 10'h3FF;
    end else begin
      q <= d;
    end
  end

  // Pass-through gates; a gated line idles at mark
  assign txToHost   = q.upEn ? q.bs2 : q.txSh[0];
  assign txToBelow  = q.downEn ? q.hs2 : 1'b1;
  assign rtsToHost  = q.rts | (q.upEn & q.rs2);
  assign numbered   = q.numbered;
  assign remoteMode = q.remote;
  assign dispLetter = q.numbered ? `DCSP_PUMP : `DCSP_SPACE;
  assign dispTens   = q.numbered ? q.nHi : `DCSP_SPACE;
  assign dispOnes   = q.numbered ? q.nLo : `DCSP_SPACE;
  assign cmdStrobe  = q.cmdStb;
  assign cmdChar    = q.cmdChr;
  assign enqPoll    = q.enqPls;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstN_q);

  property p_start_bit;
    $rose(q.txBusy) |-> !txToHost || q.upEn;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit"); // RULE1

  property p_stop_bit;
    $fell(q.txBusy) |-> q.txSh[0];
  endproperty
  a_stop_bit: assert property (p_stop_bit) else $error("line not at mark"); // RULE1

  property p_odd_par;
    $rose(q.txBusy) |-> (^q.txSh[8:1]) && !q.txSh[0] && q.txSh[9];
  endproperty
  a_odd_par: assert property (p_odd_par) else $error("parity not odd"); // RULE2

  property p_solicited;
    $rose(q.txBusy) |-> $past(q.ps) == PS_REPLY;
  endproperty
  a_solicited: assert property (p_solicited) else $error("unsolicited send"); // RULE3

  property p_power_up;
    $rose(rstN_q) |-> q.rts && q.downEn && q.upEn && !q.numbered;
  endproperty
  a_power_up: assert property (p_power_up) else $error("bad power-up state"); // RULE4

  property p_enq_block;
    enqHit |=> !q.downEn && !q.upEn && rtsToHost && q.ls == LS_BLOCKED;
  endproperty
  a_enq_block: assert property (p_enq_block) else $error("buffers not blocked"); // RULE6

  property p_assign;
    assignOk |=> !q.rts && q.downEn && !q.upEn && q.msg == M_ACK ##1 q.txBusy;
  endproperty
  a_assign: assert property (p_assign) else $error("assignment mishandled"); // RULE9

  property p_up_reopen;
    $rose(q.upEn) |-> $past(q.ls) == LS_GUARD && !q.txBusy;
  endproperty
  a_up_reopen: assert property (p_up_reopen) else $error("early upstream reopen"); // RULE10

  property p_ovf_nak;
    (crHit && assignWait && q.ovf) |=> q.ps == PS_REPLY && q.msg == M_NAK;
  endproperty
  a_ovf_nak: assert property (p_ovf_nak) else $error("long frame not refused"); // RULE26

  property p_bcast_quiet;
    (crHit && isBc && q.numbered && !assignWait) |=> q.ps == PS_IDLE;
  endproperty
  a_bcast_quiet: assert property (p_bcast_quiet) else $error("broadcast answered"); // RULE20

  property p_local;
    q.cmdStb |-> q.remote || isReq(q.cmdChr);
  endproperty
  a_local: assert property (p_local) else $error("control cmd in local"); // RULE18

  c_numbered: cover property (assignOk ##1 q.ps == PS_REPLY);
  c_renumber: cover property (crHit && isOurs && q.cmd == `DCSP_RENUM);
  c_nak: cover property (q.ps == PS_REPLY && q.msg == M_NAK);
  c_reopen: cover property ($rose(q.upEn));
endmodule
`default_nettype wire

// File: core/dcsp_defines.svh
// Constants for the daisy-chain satellite protocol engine
// Functional notes
// RULE1: Characters use start, seven data, odd parity, stop; full duplex at 4800 bit/s.
// RULE2: Data plus parity carry an odd count of ones; the receiver checks it.
// RULE3: Satellite never transmits unasked; it may only raise its request line.
// RULE4: After power-up both pass-through buffers are on and request is raised.
// RULE5: The master answers an active request line with the enquire character.
// RULE6: Enquire while requesting turns off both buffers toward lower units.
// RULE7: An unnumbered unit answers enquire with a framed model-class string.
// RULE8: The master assigns addresses from 01 upward, one per unit, up to 25.
// RULE9: Good assignment drops request, opens downstream path, then sends acknowledge.
// RULE10: Upstream path from lower units reopens within 100 ms after the reply.
// RULE11: A numbered unit shows the pump letter and its two digits.
// RULE12: After an acknowledge the master polls the next requesting unit.
// RULE13: Bad data or line errors get a negative acknowledge; master resends.
// RULE14: Late units get temporary addresses from 89 downward.
// RULE15: Renumber frame holds old address, rename character, new address; unit adopts it.
// RULE16: With 25 addresses issued, the master gives the next unit 89.
// RULE17: Power loss forgets the address and restarts the unnumbered behaviour.
// RULE18: In local mode the unit keeps its address, serves requests, ignores control.
// RULE19: Frames open with 02 hex, unit letter, two-digit address 01 to 89.
// RULE20: Addresses 00 and 90 to 98 are reserved; 99 is broadcast.
// RULE21: Up to 32 parameter characters, frame ends with 0D hex; single-character codes unframed.
// RULE22: Chained commands allowed; whole frame at most 38 characters.
// RULE23: A good non-broadcast command is answered with 06 hex.
// RULE24: The enquire character is 05 hex.
// RULE25: Receiver samples bits at their centre and flags parity or framing faults.
// RULE26: Frames longer than the maximum are dropped and negatively acknowledged.
`ifndef DCSP_DEFINES_SVH
`define DCSP_DEFINES_SVH
`define DCSP_CLK_HZ      125000000
`define DCSP_BAUD        4800
`define DCSP_BIT_CYC     (`DCSP_CLK_HZ / `DCSP_BAUD)
`define DCSP_UP_MAX_MS   100
`define DCSP_UP_CYC      (`DCSP_CLK_HZ / 1000 * `DCSP_UP_MAX_MS)
`define DCSP_FRAME_BITS  4'hA
`define DCSP_CHAR_W      8
`define DCSP_FIFO_DEPTH  32
`define DCSP_STX         7'h02
`define DCSP_ENQ         7'h05
`define DCSP_ACK         7'h06
`define DCSP_NAK         7'h15
`define DCSP_CR          7'h0D
`define DCSP_SPACE       7'h20
`define DCSP_PUMP        7'h50
`define DCSP_QMARK       7'h3F
`define DCSP_RENUM       7'h55
`define DCSP_LOCAL       7'h4C
`define DCSP_REQ_AUX     7'h41
`define DCSP_REQ_STAT    7'h49
`define DCSP_DIGIT0      7'h30
`define DCSP_DIGIT8      7'h38
`define DCSP_DIGIT9      7'h39
`define DCSP_MAX_FRAME   6'h26
`define DCSP_IX_LETTER   6'h01
`define DCSP_IX_ADR_HI   6'h02
`define DCSP_IX_ADR_LO   6'h03
`define DCSP_IX_CMD      6'h04
`define DCSP_IX_NEW_HI   6'h05
`define DCSP_IX_NEW_LO   6'h06
`define DCSP_IX_RENUM_CR 6'h07
`endif

// File: core/dcsp_pkg.sv
// Types shared by the satellite protocol engine
`default_nettype none
package dcsp_pkg;
  typedef enum logic [2:0] {PS_IDLE = 3'h1, PS_FRAME = 3'h2, PS_REPLY = 3'h4} dcsp_pstate_t;
  typedef enum logic [2:0] {LS_OPEN = 3'h1, LS_BLOCKED = 3'h2, LS_GUARD = 3'h4} dcsp_lstate_t;
  typedef enum logic [1:0] {M_ACK = 2'h0, M_NAK = 2'h1, M_CLASS = 2'h2} dcsp_msg_t;
  typedef struct packed {
    logic hs1, hs2, bs1, bs2, rs1, rs2, ms1, ms2;
    dcsp_pstate_t ps;
    dcsp_lstate_t ls;
    logic rts, downEn, upEn, numbered, remote;
    logic [6:0] nHi, nLo;
    logic [5:0] ix;
    logic ovf, err;
    logic [6:0] letter, aHi, aLo, cmd, wHi, wLo;
    dcsp_msg_t msg;
    logic [2:0] msgIx;
    logic txBusy;
    logic [15:0] txCnt;
    logic [3:0] txBit;
    logic [9:0] txSh;
    logic [23:0] guard;
    logic cmdStb, enqPls;
    logic [6:0] cmdChr;
  } dcsp_state_t;
endpackage
`default_nettype wire

// File: core/dcsp_stream_if.sv
// Valid/ready character stream between engine parts
`timescale 1ns/10ps
`default_nettype none
interface dcsp_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: core/dcsp_uart_rx.sv
// Serial character receiver with parity, framing and overrun flag
`timescale 1ns/10ps
`default_nettype none
`include "dcsp_defines.svh"
module dcsp_uart_rx
  import dcsp_pkg::*;
#(
  parameter int BIT_CYC = `DCSP_BIT_CYC
) (
  input  wire logic    core_clk,
  input  wire logic    rstN,
  input  wire logic    rxLine,
  dcsp_stream_if.src   out
);
  typedef struct packed {
    logic busy, vld;
    logic [15:0] cnt;
    logic [3:0] idx;
    logic [7:0] sh, dat;
  } dcsp_rx_t;
  dcsp_rx_t q, d;

  always_comb begin
    d = q;
    if (q.vld && out.ready) d.vld = 1'b0;
    if (!q.busy) begin
      // Half a bit to the centre of the start bit
      if (!rxLine) begin
        d.busy = 1'b1;
        d.cnt  = 16'(BIT_CYC / 2); // RULE25
        d.idx  = 4'h0;
      end
    end else if (q.cnt != 16'h0000) begin
      d.cnt = q.cnt - 16'h0001;
    end else begin
      d.cnt = 16'(BIT_CYC - 1);
      d.idx = q.idx + 4'h1;
      if (q.idx == 4'h0) d.busy = !rxLine;
      else if (q.idx < 4'h9) d.sh = {rxLine, q.sh[7:1]};
      else begin
        // Error bit: bad stop, even parity, or unread previous character
        d.busy = 1'b0;
        d.vld  = 1'b1;
        d.dat  = {!rxLine | !(^q.sh) | (q.vld & !out.ready), q.sh[6:0]}; // RULE2 RULE25
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) q <= '0;
    else q <= d;
  end

  assign out.valid = q.vld;
  assign out.data  = q.dat;
endmodule
`default_nettype wire

// File: core/dcsp_fifo.sv
// Character FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dcsp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic    core_clk,
  input  wire logic    rstN,
  dcsp_stream_if.snk   wr,
  dcsp_stream_if.src   rd
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp, rp;
  } dcsp_ff_t;
  dcsp_ff_t     q, d;
  logic [W-1:0] mem [DEPTH];
  logic         full, empty;

  assign empty = (q.wp == q.rp);
  assign full  = (q.wp[AW] != q.rp[AW]) && (q.wp[AW-1:0] == q.rp[AW-1:0]);

  always_comb begin
    d = q;
    if (wr.valid && !full) d.wp = q.wp + 1'b1;
    if (rd.ready && !empty) d.rp = q.rp + 1'b1;
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) q <= '0;
    else q <= d;
  end

  always_ff @(posedge core_clk) begin
    if (wr.valid && !full) mem[q.wp[AW-1:0]] <= wr.data;
  end

  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[q.rp[AW-1:0]];
endmodule
`default_nettype wire

// File: verif/dcsp_host_model.sv
// Serial master model: sends framed characters and collects the unit's replies
`timescale 1ns/10ps
`default_nettype none
module dcsp_host_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic core_clk,
  input  wire logic txToHost,
  output var logic  rxFromHost
);
  logic [7:0] rxQ[$];

  initial rxFromHost = 1'b1;

  // Bad flips the parity bit so the unit sees a line error
  task automatic sendChar(input logic [6:0] c, input bit bad);
    logic [9:0] f;
    f = {1'b1, (~^c) ^ bad, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      #1 rxFromHost = f[i];
      repeat (BIT_CYC - 1) @(posedge core_clk);
    end
  endtask

  // Bit 7 of a queued character marks a parity or stop-bit fault
  initial forever begin : rxLoop
    logic [7:0] s;
    @(negedge txToHost);
    repeat (BIT_CYC / 2) @(posedge core_clk);
    if (txToHost === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge core_clk);
        s[i] = txToHost;
      end
      repeat (BIT_CYC) @(posedge core_clk);
      rxQ.push_back({~(^s) | ~txToHost, s[6:0]});
    end
  end
endmodule
`default_nettype wire

// File: verif/test_dcsp_satellite.sv
// Self-checking bench for the satellite protocol engine
`timescale 1ns/10ps
`default_nettype none
module test_dcsp_satellite;
  localparam int BC = 16;
  localparam int UC = 50;
  logic       core_clk, reset_n, rxFromBelow, rtsFromBelow, modelSlow, attnReq;
  logic       rxFromHost, txToHost, rtsToHost, txToBelow, numbered, remoteMode;
  logic       cmdStrobe, enqPoll;
  logic [6:0] dispLetter, dispTens, dispOnes, cmdChar, lastCmd, cls;
  int         errors, total_checks, seed, nn, mm, strobes, polls;

  dcsp_satellite #(.BIT_CYC(BC), .UP_CYC(UC), .FIFO_DEPTH(32), .CLASS_FAST(7'h41),
    .CLASS_SLOW(7'h42)) i_dcsp_satellite (.core_clk(core_clk), .reset_n(reset_n),
    .rxFromHost(rxFromHost), .txToHost(txToHost), .rtsToHost(rtsToHost),
    .txToBelow(txToBelow), .rxFromBelow(rxFromBelow), .rtsFromBelow(rtsFromBelow),
    .modelSlow(modelSlow), .attnReq(attnReq), .numbered(numbered),
    .remoteMode(remoteMode), .dispLetter(dispLetter), .dispTens(dispTens),
    .dispOnes(dispOnes), .cmdStrobe(cmdStrobe), .cmdChar(cmdChar), .enqPoll(enqPoll));

  dcsp_host_model #(.BIT_CYC(BC)) i_dcsp_host_model (.core_clk(core_clk),
    .txToHost(txToHost), .rxFromHost(rxFromHost));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (cmdStrobe === 1'b1) begin
      strobes++;
      lastCmd = cmdChar;
    end
    if (enqPoll === 1'b1) polls++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Sends one string, framed or alone, and checks the downstream path meanwhile
  task automatic sendF(input string s, input int bad, input bit fr, input logic expDown);
    fork
      begin
        if (fr) i_dcsp_host_model.sendChar(7'h02, 1'b0);
        foreach (s[i]) i_dcsp_host_model.sendChar(7'(s[i]), i == bad);
        if (fr) i_dcsp_host_model.sendChar(7'h0D, 1'b0);
      end
      begin
        repeat (4) @(posedge core_clk);
        #2 check(txToBelow, expDown);
      end
    join
  endtask

  // Expected reply is built as a queue and compared character by character
  task automatic getReply(input string s, input bit fr);
    logic [7:0] e[$];
    if (fr) e.push_back(8'h02);
    foreach (s[i]) e.push_back({1'b0, 7'(s[i])});
    if (fr) e.push_back(8'h0D);
    for (int k = 0; k < 20000 && i_dcsp_host_model.rxQ.size() < e.size(); k++)
      @(posedge core_clk);
    foreach (e[i])
      check(i_dcsp_host_model.rxQ.size() ? i_dcsp_host_model.rxQ.pop_front() : 32'hFFFF,
            e[i]);
  endtask

  task automatic cmdTest(input string s, input int expN, input logic [6:0] c);
    int n0;
    n0 = strobes;
    sendF(s, -1, 1'b1, 1'b0);
    repeat (2 * BC) @(posedge core_clk);
    check(strobes - n0, expN);
    if (expN > 0) check(lastCmd, c);
  endtask

  initial begin
    errors = 0; total_checks = 0; strobes = 0; polls = 0;
    seed = 32'hc227;
    nn = 1 + ($unsigned($random(seed)) % 25);
    mm = 26 + ($unsigned($random(seed)) % 64);
    reset_n = 1'b0; rxFromBelow = 1'b1; rtsFromBelow = 1'b0; attnReq = 1'b0;
    modelSlow = 1'($random(seed));
    cls = modelSlow ? 7'h42 : 7'h41;
    repeat (16) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge core_clk);
    check(rtsToHost, 1'b1);
    check({numbered, dispLetter}, {1'b0, 7'h20});
    sendF($sformatf("%c", 8'h05), -1, 1'b0, 1'b0);
    getReply($sformatf("P?%c", cls), 1'b1);
    sendF($sformatf("P%02d", nn), 2, 1'b1, 1'b1);
    getReply($sformatf("%c", 8'h15), 1'b0);
    sendF("P0000000000000000000000000000000000000000", -1, 1'b1, 1'b1);
    getReply($sformatf("%c", 8'h15), 1'b0);
    #1 rtsFromBelow = 1'b1;
    sendF($sformatf("P%02d", nn), -1, 1'b1, 1'b1);
    getReply($sformatf("%c", 8'h06), 1'b0);
    check(rtsToHost, 1'b0);
    check({numbered, dispLetter}, {1'b1, 7'h50});
    check({dispTens, dispOnes}, {7'h30 + 7'(nn / 10), 7'h30 + 7'(nn % 10)});
    repeat (UC + 20) @(posedge core_clk);
    check(rtsToHost, 1'b1);
    #1 rtsFromBelow = 1'b0;
    cmdTest($sformatf("P%02dI", nn), 1, 7'h49);
    cmdTest("P99G", 1, 7'h47);
    cmdTest("P00G", 0, 7'h47);
    cmdTest("P95G", 0, 7'h47);
    cmdTest($sformatf("P%02dS+0500.0V08255.37G", nn), 1, 7'h53);
    cmdTest($sformatf("P%02dV%032d", nn, 5), 1, 7'h56);
    cmdTest($sformatf("P%02dV%033d", nn, 5), 0, 7'h56);
    cmdTest($sformatf("P%02dU%02d", nn, mm), 0, 7'h55);
    check({dispTens, dispOnes}, {7'h30 + 7'(mm / 10), 7'h30 + 7'(mm % 10)});
    cmdTest($sformatf("P%02dI", nn), 0, 7'h49);
    cmdTest($sformatf("P%02dL", mm), 0, 7'h4C);
    check({numbered, remoteMode}, 2'b10);
    cmdTest($sformatf("P%02dA", mm), 1, 7'h41);
    cmdTest($sformatf("P%02dG", mm), 0, 7'h47);
    @(posedge core_clk);
    #1 attnReq = 1'b1;
    @(posedge core_clk);
    #1 attnReq = 1'b0;
    repeat (3) @(posedge core_clk);
    check(rtsToHost, 1'b1);
    sendF($sformatf("%c", 8'h05), -1, 1'b0, 1'b0);
    repeat (2 * BC) @(posedge core_clk);
    check(polls, 1);
    sendF($sformatf("%c", 8'h06), -1, 1'b0, 1'b1);
    repeat (UC + 2 * BC) @(posedge core_clk);
    check(rtsToHost, 1'b0);
    check(i_dcsp_host_model.rxQ.size(), 0);
    #1 reset_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge core_clk);
    check({numbered, rtsToHost, dispTens}, {2'b01, 7'h20});
    // Unit rejoins after commands were issued, so it gets the temporary top address
    sendF($sformatf("%c", 8'h05), -1, 1'b0, 1'b0);
    getReply($sformatf("P?%c", cls), 1'b1);
    sendF("P89", -1, 1'b1, 1'b1);
    getReply($sformatf("%c", 8'h06), 1'b0);
    check({numbered, dispTens, dispOnes}, {1'b1, 7'h38, 7'h39});
    stop_test();
  end

  // Whole run needs roughly 40000 cycles
  initial begin
    repeat (90000) @(posedge core_clk);
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
